// >>> tfmc_pkg.sv
// Package for the timing framer mode and interrupt control block.
// Assumes a 100 MHz core clock and a classic Wishbone slave port.
package tfmc_pkg;

  localparam int CLK_KHZ = 100000;
  localparam int RAI_INTEG_MS = 200;
  localparam int RAI_INTEG_CYCLES = RAI_INTEG_MS * CLK_KHZ;

  localparam logic [5:0] IDX_LINE_EVENT = 6'h1A;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h1B;
  localparam logic [5:0] IDX_RX_MODE    = 6'h20;
  localparam logic [5:0] IDX_TX_MODE    = 6'h21;
  localparam logic [5:0] IDX_SYNC_CFG   = 6'h22;
  localparam logic [5:0] IDX_ALARM_CFG  = 6'h23;
  localparam logic [5:0] IDX_E1_CFG     = 6'h24;
  localparam logic [5:0] IDX_STATUS     = 6'h2A;

  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] EVENT_BITS = 8'h77;
  localparam logic [7:0] MODE_BITS  = 8'hC3;
  localparam logic [7:0] ALARM_BITS = 8'h0F;
  localparam logic [7:0] E1_BITS    = 8'h7F;

  localparam int BIT_ENABLE = 7;
  localparam int BIT_INIT   = 6;
  localparam int BIT_SRST   = 1;
  localparam int BIT_STD    = 0;
  localparam int EVT_FALL_LSB = 4;
  localparam int EVT_RISE_LSB = 0;

  localparam int BIT_SYNC_QUAL  = 7;
  localparam int BIT_ZERO_SUB   = 6;
  localparam int BIT_FRAME_FMT  = 5;
  localparam int BIT_ARC        = 4;
  localparam int BIT_SYNC_CRIT  = 3;
  localparam int BIT_JAPAN_CRC  = 2;
  localparam int BIT_SYNC_DIS   = 1;
  localparam int BIT_RESYNC     = 0;
  localparam int BIT_OUT_OF_FRAME_CRITERION_LSB   = 2;
  localparam int BIT_RAI_INTEG  = 1;
  localparam int BIT_SF_ALARM   = 0;
  localparam int BIT_E1_DECODE  = 6;

  localparam logic [4:0] SYNC_BITS_SHORT = 5'h0A;
  localparam logic [4:0] SYNC_BITS_LONG  = 5'h18;
  localparam logic [2:0] OOF_WIN_4 = 3'h4;
  localparam logic [2:0] OOF_WIN_5 = 3'h5;
  localparam logic [2:0] OOF_WIN_6 = 3'h6;

  localparam int RAI_WINDOW = 16;
  localparam logic [4:0] RAI_CLEAR_MAX = 5'h0E;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tfmc_wb_req_s;

  typedef struct packed {
    logic open_circuit;
    logic short_circuit;
    logic signal_lost;
  } tfmc_line_s;

  typedef struct packed {
    logic pattern_valid;
    logic pattern_alarm;
    logic sf_bit2_zeros;
    logic sf_fs12_one;
  } tfmc_alarm_in_s;

  typedef enum logic [1:0] {
    ENG_OFF     = 2'b00,
    ENG_RESET   = 2'b01,
    ENG_WAIT    = 2'b10,
    ENG_ACTIVE  = 2'b11
  } tfmc_eng_e;

endpackage

// >>> tfmc_rai_detect.sv
// Remote alarm detector for the DS1 receive framer.
// Assumes pattern strobes and alarm conditions come from logic on the same clock.
module tfmc_rai_detect #(
  parameter int INTEG_CYCLES = tfmc_pkg::RAI_INTEG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hold,
  input  wire logic superframe,
  input  wire logic integrate_en,
  input  wire logic sf_alarm_type,
  input  wire tfmc_pkg::tfmc_alarm_in_s alarm_in,
  output logic      remote_alarm
);

  logic [tfmc_pkg::RAI_WINDOW-1:0] history;
  logic [4:0]                      hits;
  logic                            fdl_alarm;
  logic                            next_fdl_alarm;
  logic [24:0]                     integ_count;
  logic                            integ_state;

  always_comb begin
    hits = 5'h00;
    for (int i = 0; i < tfmc_pkg::RAI_WINDOW; i++) begin
      hits = hits + {4'h0, history[i]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || hold) begin
      history <= '0;
    end else if (alarm_in.pattern_valid) begin
      history <= {history[tfmc_pkg::RAI_WINDOW-2:0], alarm_in.pattern_alarm};
    end
  end

  always_comb begin
    next_fdl_alarm = fdl_alarm;
    if (&history) begin
      next_fdl_alarm = 1'b1;
    end else if (hits <= tfmc_pkg::RAI_CLEAR_MAX) begin
      next_fdl_alarm = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || hold) begin
      fdl_alarm <= 1'b0;
    end else begin
      fdl_alarm <= next_fdl_alarm;
    end
  end

  // The integrator only changes state once the raw condition has disagreed with it for longer than INTEG_CYCLES cycles.
  always_ff @(posedge clk) begin
    if (rst || hold) begin
      integ_count <= 25'h0000000;
      integ_state <= 1'b0;
    end else if (fdl_alarm == integ_state) begin
      integ_count <= 25'h0000000;
    end else if (integ_count > 25'(INTEG_CYCLES - 1)) begin
      integ_state <= fdl_alarm;
      integ_count <= 25'h0000000;
    end else begin
      integ_count <= integ_count + 25'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || hold) begin
      remote_alarm <= 1'b0;
    end else if (superframe) begin
      remote_alarm <= sf_alarm_type ? alarm_in.sf_fs12_one : alarm_in.sf_bit2_zeros;
    end else if (integrate_en) begin
      remote_alarm <= integ_state;
    end else begin
      remote_alarm <= fdl_alarm;
    end
  end

endmodule

// >>> tfmc_top.sv
// Mode, configuration and line alarm interrupt control for one timing transceiver channel.
// Assumes a classic Wishbone master on CLOCK and line status pins from the analog interface.

// Contract
// - Bits 6..4 mask removed-condition events.
// - Bits 2..0 mask detected-condition events.
// - Events latch on edges; write one clears.
// - Receive enable zero keeps framer low power.
// - Receiver activates after init done and enable.
// - Transmit enable zero keeps formatter low power.
// - Transmitter activates after init done and enable.
// - Soft reset bits hold engine while set.
// - Independent T1/E1 select per direction.
// - Sync qualifies ten or twenty-four framing bits.
// - Bit 6 enables zero-substitution decode.
// - Bit 5 picks extended or plain superframe.
// - Auto resync on OOF/SIGNAL_LOST_EVENT or OOF.
// - Sync criterion selects frame search method.
// - Bit 2 selects Japanese CRC-6.
// - Sync disable suppresses automatic search.
// - Resync starts on rising resync bit.
// - Out-of-frame window four, five or six.
// - Unintegrated alarm: sixteen set, fourteen clear.
// - Integrated alarm needs 200 ms persistence.
// - Superframe alarm type: bit two or Fs.
// - E1 bit 6 enables HDB3 decode.
module tfmc_top #(
  parameter int RAI_INTEG_CYCLES = tfmc_pkg::RAI_INTEG_CYCLES
) (
  input  wire logic                     CLOCK,
  input  wire logic                     SYS_RST,
  input  wire tfmc_pkg::tfmc_wb_req_s   WB_REQ,
  output logic [31:0]                   WB_DAT_O,
  output logic                          WB_ACK_O,
  input  wire tfmc_pkg::tfmc_line_s     LINE_STATUS,
  input  wire logic                     OOF_EVENT,
  input  wire tfmc_pkg::tfmc_alarm_in_s ALARM_IN,
  output logic                          IRQ_REQUEST_OUT,
  output logic                          RX_FRAMER_ACTIVE,
  output logic                          RX_LOW_POWER,
  output logic                          RX_FRAMER_RESET,
  output logic                          RX_LINE_STANDARD_SEL,
  output logic                          TX_FORMATTER_ACTIVE,
  output logic                          TX_LOW_POWER,
  output logic                          TX_FORMATTER_RESET,
  output logic                          TX_LINE_STANDARD_SEL,
  output logic [4:0]                    SYNC_QUALIFY_COUNT,
  output logic                          RX_ZERO_SUB_DECODE_EN,
  output logic                          RX_FRAME_FORMAT,
  output logic                          SYNC_SEARCH_CRITERION,
  output logic                          RX_JAPAN_CRC_SEL,
  output logic [2:0]                    OUT_OF_FRAME_WINDOW,
  output logic                          RESYNC_START,
  output logic                          REMOTE_ALARM,
  output logic                          RX_E1_LINE_DECODE_EN
);

  logic [2:0]  line_meta;
  logic [2:0]  line_sync;
  logic [2:0]  line_prev;
  logic [2:0]  line_rise;
  logic [2:0]  line_fall;
  logic [7:0]  line_event_latch_reg;
  logic [7:0]  line_alarm_irq_mask;
  logic [7:0]  receive_master_mode;
  logic [7:0]  transmit_master_mode;
  logic [7:0]  ds1_receive_sync_config;
  logic [7:0]  ds1_receive_alarm_config;
  logic [7:0]  e1_receive_config;
  logic [7:0]  status_view;
  logic [7:0]  read_byte;
  logic [5:0]  reg_index;
  logic        bus_req;
  logic        wr_take;
  logic        rx_line_standard_sel;
  logic        resync_bit;
  logic        resync_prev;
  logic        sync_disable;
  logic        auto_trigger;
  logic        remote_alarm;
  logic        rx_hold;
  tfmc_pkg::tfmc_eng_e rx_state;
  tfmc_pkg::tfmc_eng_e next_rx_state;
  tfmc_pkg::tfmc_eng_e tx_state;
  tfmc_pkg::tfmc_eng_e next_tx_state;

  assign bus_req   = WB_REQ.cyc && WB_REQ.stb;
  assign reg_index = WB_REQ.adr[7:2];
  // Writes take effect on the same edge at which the master samples the acknowledge.
  assign wr_take   = bus_req && WB_REQ.we && WB_ACK_O && WB_REQ.sel[0];

  assign rx_line_standard_sel = receive_master_mode[tfmc_pkg::BIT_STD];

  // Line status arrives from the analog side, so each bit passes two flops before the edge detector.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_line
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          line_meta[g] <= 1'b0;
          line_sync[g] <= 1'b0;
          line_prev[g] <= 1'b0;
        end else begin
          line_meta[g] <= LINE_STATUS[g];
          line_sync[g] <= line_meta[g];
          line_prev[g] <= line_sync[g];
        end
      end
      assign line_rise[g] = line_sync[g] && !line_prev[g];
      assign line_fall[g] = !line_sync[g] && line_prev[g];

      // A new edge in the clearing cycle keeps the bit set.
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          line_event_latch_reg[tfmc_pkg::EVT_RISE_LSB+g] <= 1'b0;
          line_event_latch_reg[tfmc_pkg::EVT_FALL_LSB+g] <= 1'b0;
        end else begin
          line_event_latch_reg[tfmc_pkg::EVT_RISE_LSB+g] <= line_rise[g] ||
            (line_event_latch_reg[tfmc_pkg::EVT_RISE_LSB+g] &&
             !(wr_take && reg_index == tfmc_pkg::IDX_LINE_EVENT &&
               WB_REQ.dat[tfmc_pkg::EVT_RISE_LSB+g]));
          line_event_latch_reg[tfmc_pkg::EVT_FALL_LSB+g] <= line_fall[g] ||
            (line_event_latch_reg[tfmc_pkg::EVT_FALL_LSB+g] &&
             !(wr_take && reg_index == tfmc_pkg::IDX_LINE_EVENT &&
               WB_REQ.dat[tfmc_pkg::EVT_FALL_LSB+g]));
        end
      end
    end
  endgenerate

  assign line_event_latch_reg[3] = 1'b0;
  assign line_event_latch_reg[7] = 1'b0;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      line_alarm_irq_mask <= tfmc_pkg::REG_RESET;
    end else if (wr_take && reg_index == tfmc_pkg::IDX_IRQ_MASK) begin
      line_alarm_irq_mask <= WB_REQ.dat[7:0] & tfmc_pkg::EVENT_BITS;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ_REQUEST_OUT <= 1'b0;
    end else begin
      IRQ_REQUEST_OUT <= |(line_event_latch_reg & line_alarm_irq_mask);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      receive_master_mode  <= tfmc_pkg::REG_RESET;
      transmit_master_mode <= tfmc_pkg::REG_RESET;
    end else if (wr_take) begin
      if (reg_index == tfmc_pkg::IDX_RX_MODE) begin
        receive_master_mode <= WB_REQ.dat[7:0] & tfmc_pkg::MODE_BITS;
      end
      if (reg_index == tfmc_pkg::IDX_TX_MODE) begin
        transmit_master_mode <= WB_REQ.dat[7:0] & tfmc_pkg::MODE_BITS;
      end
    end
  end

  // Configuration registers are stored regardless of mode; DS1 fields but zero-sub, resync, sync disable and alarm bits 1..0 steer logic in either standard.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ds1_receive_sync_config  <= tfmc_pkg::REG_RESET;
      ds1_receive_alarm_config <= tfmc_pkg::REG_RESET;
      e1_receive_config        <= tfmc_pkg::REG_RESET;
    end else if (wr_take) begin
      if (reg_index == tfmc_pkg::IDX_SYNC_CFG) begin
        ds1_receive_sync_config <= WB_REQ.dat[7:0];
      end
      if (reg_index == tfmc_pkg::IDX_ALARM_CFG) begin
        ds1_receive_alarm_config <= WB_REQ.dat[7:0] & tfmc_pkg::ALARM_BITS;
      end
      if (reg_index == tfmc_pkg::IDX_E1_CFG) begin
        e1_receive_config <= WB_REQ.dat[7:0] & tfmc_pkg::E1_BITS;
      end
    end
  end

  // Engine sequencing: soft reset dominates, then the enable, then the init-done handshake.
  always_comb begin
    next_rx_state = rx_state;
    if (receive_master_mode[tfmc_pkg::BIT_SRST]) begin
      next_rx_state = tfmc_pkg::ENG_RESET;
    end else begin
      case (rx_state)
        tfmc_pkg::ENG_RESET: next_rx_state = tfmc_pkg::ENG_WAIT;
        tfmc_pkg::ENG_OFF,
        tfmc_pkg::ENG_WAIT: begin
          if (!receive_master_mode[tfmc_pkg::BIT_ENABLE]) begin
            next_rx_state = tfmc_pkg::ENG_OFF;
          end else if (receive_master_mode[tfmc_pkg::BIT_INIT]) begin
            next_rx_state = tfmc_pkg::ENG_ACTIVE;
          end else begin
            next_rx_state = tfmc_pkg::ENG_WAIT;
          end
        end
        tfmc_pkg::ENG_ACTIVE: begin
          if (!receive_master_mode[tfmc_pkg::BIT_ENABLE]) begin
            next_rx_state = tfmc_pkg::ENG_OFF;
          end else if (!receive_master_mode[tfmc_pkg::BIT_INIT]) begin
            next_rx_state = tfmc_pkg::ENG_WAIT;
          end
        end
        default: next_rx_state = tfmc_pkg::ENG_OFF;
      endcase
    end
  end

  always_comb begin
    next_tx_state = tx_state;
    if (transmit_master_mode[tfmc_pkg::BIT_SRST]) begin
      next_tx_state = tfmc_pkg::ENG_RESET;
    end else begin
      case (tx_state)
        tfmc_pkg::ENG_RESET: next_tx_state = tfmc_pkg::ENG_WAIT;
        tfmc_pkg::ENG_OFF,
        tfmc_pkg::ENG_WAIT: begin
          if (!transmit_master_mode[tfmc_pkg::BIT_ENABLE]) begin
            next_tx_state = tfmc_pkg::ENG_OFF;
          end else if (transmit_master_mode[tfmc_pkg::BIT_INIT]) begin
            next_tx_state = tfmc_pkg::ENG_ACTIVE;
          end else begin
            next_tx_state = tfmc_pkg::ENG_WAIT;
          end
        end
        tfmc_pkg::ENG_ACTIVE: begin
          if (!transmit_master_mode[tfmc_pkg::BIT_ENABLE]) begin
            next_tx_state = tfmc_pkg::ENG_OFF;
          end else if (!transmit_master_mode[tfmc_pkg::BIT_INIT]) begin
            next_tx_state = tfmc_pkg::ENG_WAIT;
          end
        end
        default: next_tx_state = tfmc_pkg::ENG_OFF;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rx_state <= tfmc_pkg::ENG_OFF;
      tx_state <= tfmc_pkg::ENG_OFF;
    end else begin
      rx_state <= next_rx_state;
      tx_state <= next_tx_state;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      RX_FRAMER_ACTIVE     <= 1'b0;
      RX_LOW_POWER         <= 1'b1;
      RX_FRAMER_RESET      <= 1'b0;
      RX_LINE_STANDARD_SEL <= 1'b0;
      TX_FORMATTER_ACTIVE  <= 1'b0;
      TX_LOW_POWER         <= 1'b1;
      TX_FORMATTER_RESET   <= 1'b0;
      TX_LINE_STANDARD_SEL <= 1'b0;
    end else begin
      RX_FRAMER_ACTIVE     <= next_rx_state == tfmc_pkg::ENG_ACTIVE;
      RX_LOW_POWER         <= !receive_master_mode[tfmc_pkg::BIT_ENABLE];
      RX_FRAMER_RESET      <= receive_master_mode[tfmc_pkg::BIT_SRST];
      RX_LINE_STANDARD_SEL <= rx_line_standard_sel;
      TX_FORMATTER_ACTIVE  <= next_tx_state == tfmc_pkg::ENG_ACTIVE;
      TX_LOW_POWER         <= !transmit_master_mode[tfmc_pkg::BIT_ENABLE];
      TX_FORMATTER_RESET   <= transmit_master_mode[tfmc_pkg::BIT_SRST];
      TX_LINE_STANDARD_SEL <= transmit_master_mode[tfmc_pkg::BIT_STD];
    end
  end

  // Only the zero-substitution and E1 decode enables read as off while the other standard is selected.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      SYNC_QUALIFY_COUNT    <= tfmc_pkg::SYNC_BITS_SHORT;
      RX_ZERO_SUB_DECODE_EN <= 1'b0;
      RX_FRAME_FORMAT       <= 1'b0;
      SYNC_SEARCH_CRITERION <= 1'b0;
      RX_JAPAN_CRC_SEL      <= 1'b0;
      OUT_OF_FRAME_WINDOW   <= tfmc_pkg::OOF_WIN_4;
      RX_E1_LINE_DECODE_EN  <= 1'b0;
    end else begin
      SYNC_QUALIFY_COUNT <= ds1_receive_sync_config[tfmc_pkg::BIT_SYNC_QUAL] ?
                            tfmc_pkg::SYNC_BITS_LONG : tfmc_pkg::SYNC_BITS_SHORT;
      RX_ZERO_SUB_DECODE_EN <= !rx_line_standard_sel &&
                               ds1_receive_sync_config[tfmc_pkg::BIT_ZERO_SUB];
      RX_FRAME_FORMAT       <= ds1_receive_sync_config[tfmc_pkg::BIT_FRAME_FMT];
      SYNC_SEARCH_CRITERION <= ds1_receive_sync_config[tfmc_pkg::BIT_SYNC_CRIT];
      RX_JAPAN_CRC_SEL      <= ds1_receive_sync_config[tfmc_pkg::BIT_JAPAN_CRC];
      case (ds1_receive_alarm_config[tfmc_pkg::BIT_OUT_OF_FRAME_CRITERION_LSB +: 2])
        2'b00:   OUT_OF_FRAME_WINDOW <= tfmc_pkg::OOF_WIN_4;
        2'b01:   OUT_OF_FRAME_WINDOW <= tfmc_pkg::OOF_WIN_5;
        default: OUT_OF_FRAME_WINDOW <= tfmc_pkg::OOF_WIN_6;
      endcase
      RX_E1_LINE_DECODE_EN <= rx_line_standard_sel &&
                              e1_receive_config[tfmc_pkg::BIT_E1_DECODE];
    end
  end

  // Sync disable and resync live in the DS1 or E1 register according to the receive standard.
  assign resync_bit   = rx_line_standard_sel ? e1_receive_config[tfmc_pkg::BIT_RESYNC] :
                        ds1_receive_sync_config[tfmc_pkg::BIT_RESYNC];
  assign sync_disable = rx_line_standard_sel ? e1_receive_config[tfmc_pkg::BIT_SYNC_DIS] :
                        ds1_receive_sync_config[tfmc_pkg::BIT_SYNC_DIS];
  assign auto_trigger = !sync_disable && (OOF_EVENT ||
                        (line_rise[0] && !ds1_receive_sync_config[tfmc_pkg::BIT_ARC]));

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      resync_prev  <= 1'b0;
      RESYNC_START <= 1'b0;
    end else begin
      resync_prev  <= resync_bit;
      RESYNC_START <= RX_FRAMER_ACTIVE && ((resync_bit && !resync_prev) || auto_trigger);
    end
  end

  // The alarm detector idles whenever the receiver is not running DS1.
  assign rx_hold = !RX_FRAMER_ACTIVE || rx_line_standard_sel;

  tfmc_rai_detect #(
    .INTEG_CYCLES(RAI_INTEG_CYCLES)
  ) u_rai (
    .clk          (CLOCK),
    .rst          (SYS_RST),
    .hold         (rx_hold),
    .superframe   (ds1_receive_sync_config[tfmc_pkg::BIT_FRAME_FMT]),
    .integrate_en (ds1_receive_alarm_config[tfmc_pkg::BIT_RAI_INTEG]),
    .sf_alarm_type(ds1_receive_alarm_config[tfmc_pkg::BIT_SF_ALARM]),
    .alarm_in     (ALARM_IN),
    .remote_alarm (remote_alarm)
  );

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      REMOTE_ALARM <= 1'b0;
    end else begin
      REMOTE_ALARM <= remote_alarm;
    end
  end

  assign status_view = {4'h0, remote_alarm, line_sync};

  always_comb begin
    case (reg_index)
      tfmc_pkg::IDX_LINE_EVENT: read_byte = line_event_latch_reg;
      tfmc_pkg::IDX_IRQ_MASK:   read_byte = line_alarm_irq_mask;
      tfmc_pkg::IDX_RX_MODE:    read_byte = receive_master_mode;
      tfmc_pkg::IDX_TX_MODE:    read_byte = transmit_master_mode;
      tfmc_pkg::IDX_SYNC_CFG:   read_byte = ds1_receive_sync_config;
      tfmc_pkg::IDX_ALARM_CFG:  read_byte = ds1_receive_alarm_config;
      tfmc_pkg::IDX_E1_CFG:     read_byte = e1_receive_config;
      tfmc_pkg::IDX_STATUS:     read_byte = status_view;
      default:                  read_byte = 8'h00;
    endcase
  end

  // One wait state: ack follows the request by one edge and drops in the next cycle.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= bus_req && !WB_ACK_O;
      WB_DAT_O <= (bus_req && !WB_ACK_O && !WB_REQ.we) ? {24'h000000, read_byte} : 32'h00000000;
    end
  end

endmodule

// >>> tfmc_far_end.sv
// Model of the remote line equipment feeding line status, frame events and alarm patterns.
// Assumes one clock shared with the block; every change follows a rising edge.
module tfmc_far_end (
  input  wire logic                clk,
  output tfmc_pkg::tfmc_line_s     line,
  output logic                     oof,
  output tfmc_pkg::tfmc_alarm_in_s alarm
);
  initial begin
    line = '0;
    oof = 1'b0;
    alarm = '0;
  end
  task automatic set_line(input logic [2:0] v);
    @(posedge clk);
    line <= v;
  endtask
  task automatic set_sf(input logic [1:0] v);
    @(posedge clk);
    alarm <= {2'b00, v};
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_oof();
    @(posedge clk);
    oof <= 1'b1;
    @(posedge clk);
    oof <= 1'b0;
  endtask
  // The flag is inverted between strobes so a design that ignores the strobe is caught.
  task automatic send_pat(input logic bad, input int n);
    repeat (n) begin
      @(posedge clk);
      alarm <= {1'b1, bad, 2'b00};
      @(posedge clk);
      alarm <= {1'b0, ~bad, 2'b00};
    end
  endtask
endmodule

// >>> tfmc_top_sva.sv
// Checker for the mode and line alarm control block.
// Assumes it is bound to tfmc_top and sees only its ports.
module tfmc_chk (
  input wire logic                   CLOCK,
  input wire logic                   SYS_RST,
  input wire tfmc_pkg::tfmc_wb_req_s WB_REQ,
  input wire logic                   WB_ACK_O,
  input wire logic                   IRQ_REQUEST_OUT,
  input wire logic                   RX_FRAMER_ACTIVE,
  input wire logic                   RX_LOW_POWER,
  input wire logic                   RX_FRAMER_RESET,
  input wire logic                   TX_FORMATTER_ACTIVE,
  input wire logic                   TX_LOW_POWER,
  input wire logic [4:0]             SYNC_QUALIFY_COUNT,
  input wire logic [2:0]             OUT_OF_FRAME_WINDOW,
  input wire logic                   RESYNC_START
);
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic mask_off;
  assign mask_off = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && !WB_ACK_O && WB_REQ.sel[0]
                    && WB_REQ.adr[7:2] == tfmc_pkg::IDX_IRQ_MASK && WB_REQ.dat[7:0] == 8'h00;
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  ack_latency_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  rx_power_a: assert property (RX_FRAMER_ACTIVE [*2] |-> !RX_LOW_POWER) else $error("rx active in low power");
  tx_power_a: assert property (TX_FORMATTER_ACTIVE [*2] |-> !TX_LOW_POWER) else $error("tx active in low power");
  rx_reset_a: assert property (RX_FRAMER_RESET [*2] |-> !RX_FRAMER_ACTIVE) else $error("rx active in reset");
  sync_count_a: assert property (SYNC_QUALIFY_COUNT == 5'h0A || SYNC_QUALIFY_COUNT == 5'h18)
    else $error("bad sync count");
  oof_window_a: assert property (OUT_OF_FRAME_WINDOW inside {3'h4, 3'h5, 3'h6}) else $error("bad window");
  resync_active_a: assert property (RESYNC_START |-> $past(RX_FRAMER_ACTIVE)) else $error("resync idle");
  irq_mask_a: assert property (mask_off |-> ##4 !IRQ_REQUEST_OUT) else $error("irq not masked");
endmodule

bind tfmc_top tfmc_chk i_chk (.*);

// >>> timing_framer_mode_and_irq_control_tb.sv
// Self-checking bench for the mode and line alarm control block.
// Assumes the far-end model supplies line status, frame events and alarm patterns.
module timing_framer_mode_and_irq_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] EV = tfmc_pkg::IDX_LINE_EVENT, MSK = tfmc_pkg::IDX_IRQ_MASK, RXM = tfmc_pkg::IDX_RX_MODE;
  localparam logic [5:0] TXM = tfmc_pkg::IDX_TX_MODE, SYN = tfmc_pkg::IDX_SYNC_CFG, ALM = tfmc_pkg::IDX_ALARM_CFG;
  logic                     CLOCK = 1'b0;
  logic                     SYS_RST = 1'b1;
  tfmc_pkg::tfmc_wb_req_s   WB_REQ = '0;
  tfmc_pkg::tfmc_line_s     LINE_STATUS;
  tfmc_pkg::tfmc_alarm_in_s ALARM_IN;
  logic OOF_EVENT, WB_ACK_O, IRQ_REQUEST_OUT, RX_FRAMER_ACTIVE, RX_LOW_POWER, RX_FRAMER_RESET, RX_LINE_STANDARD_SEL;
  logic TX_FORMATTER_ACTIVE, TX_LOW_POWER, TX_FORMATTER_RESET, TX_LINE_STANDARD_SEL, RX_ZERO_SUB_DECODE_EN;
  logic RX_FRAME_FORMAT, SYNC_SEARCH_CRITERION, RX_JAPAN_CRC_SEL, RESYNC_START, REMOTE_ALARM, RX_E1_LINE_DECODE_EN;
  logic [31:0]              WB_DAT_O;
  logic [4:0]               SYNC_QUALIFY_COUNT;
  logic [2:0]               OUT_OF_FRAME_WINDOW;
  logic [7:0]               q;
  logic [7:0]               cfg [2] = '{8'hE4, 8'h08};
  int                       n_fail = 0, comparisons = 0, n_resync = 0;
  always #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (RESYNC_START === 1'b1) n_resync++;
  tfmc_top #(.RAI_INTEG_CYCLES(50)) i_dut (.*);
  tfmc_far_end i_far (.clk(CLOCK), .line(LINE_STATUS), .oof(OOF_EVENT), .alarm(ALARM_IN));
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
    @(posedge CLOCK);
    WB_REQ <= {2'b11, we, idx, 2'b00, 4'hF, 24'h0, d};
    do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O[7:0];
    WB_REQ <= '0;
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk("register", exp, q);
  endtask
  task automatic pat_chk(input logic bad, input int n, input logic [7:0] exp);
    i_far.send_pat(bad, n);
    repeat (4) @(posedge CLOCK);
    chk("remote alarm", exp, REMOTE_ALARM);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    foreach (cfg[i]) rd(EV + 6'(i), 8'h00);
    rd(RXM, 8'h00);
    rd(6'h3F, 8'h00);
    chk("rx low power", 8'h01, RX_LOW_POWER);
    chk("oof window", 8'h04, OUT_OF_FRAME_WINDOW);
    i_far.set_line(3'b111);
    repeat (5) @(posedge CLOCK);
    rd(EV, 8'h07);
    i_far.set_line(3'b000);
    repeat (5) @(posedge CLOCK);
    rd(EV, 8'h77);
    for (int j = 0; j < 7; j++) begin
      wb(1'b1, MSK, 8'h01 << j);
      chk("irq", (j == 3) ? 8'h00 : 8'h01, IRQ_REQUEST_OUT);
    end
    wb(1'b1, EV, 8'h3F);
    rd(EV, 8'h40);
    chk("irq", 8'h01, IRQ_REQUEST_OUT);
    wb(1'b1, MSK, 8'h00);
    chk("irq", 8'h00, IRQ_REQUEST_OUT);
    wb(1'b1, TXM, 8'h81);
    chk("tx active", 8'h00, TX_FORMATTER_ACTIVE);
    chk("tx low power", 8'h00, TX_LOW_POWER);
    chk("tx std", 8'h01, TX_LINE_STANDARD_SEL);
    chk("rx std", 8'h00, RX_LINE_STANDARD_SEL);
    wb(1'b1, TXM, 8'hC3);
    chk("tx reset", 8'h01, TX_FORMATTER_RESET);
    chk("tx active", 8'h00, TX_FORMATTER_ACTIVE);
    wb(1'b1, TXM, 8'hC1);
    chk("tx active", 8'h01, TX_FORMATTER_ACTIVE);
    wb(1'b1, RXM, 8'h40);
    chk("rx active", 8'h00, RX_FRAMER_ACTIVE);
    wb(1'b1, RXM, 8'hC2);
    chk("rx active", 8'h00, RX_FRAMER_ACTIVE);
    chk("rx reset", 8'h01, RX_FRAMER_RESET);
    wb(1'b1, RXM, 8'hC0);
    chk("rx active", 8'h01, RX_FRAMER_ACTIVE);
    for (int j = 0; j < 4; j++) begin
      wb(1'b1, ALM, 8'(j << 2));
      chk("oof window", (j == 0) ? 8'h04 : (j == 1) ? 8'h05 : 8'h06, OUT_OF_FRAME_WINDOW);
    end
    foreach (cfg[i]) begin
      wb(1'b1, SYN, cfg[i]);
      chk("sync count", cfg[i][7] ? 8'h18 : 8'h0A, SYNC_QUALIFY_COUNT);
      chk("zero sub", 8'(cfg[i][6]), RX_ZERO_SUB_DECODE_EN);
      chk("format", 8'(cfg[i][5]), RX_FRAME_FORMAT);
      chk("criterion", 8'(cfg[i][3]), SYNC_SEARCH_CRITERION);
      chk("japan crc", 8'(cfg[i][2]), RX_JAPAN_CRC_SEL);
    end
    wb(1'b1, SYN, 8'h01);
    wb(1'b1, SYN, 8'h01);
    wb(1'b1, SYN, 8'h00);
    wb(1'b1, SYN, 8'h01);
    chk("resync", 8'h02, 8'(n_resync));
    i_far.pulse_oof();
    i_far.set_line(3'b001);
    repeat (6) @(posedge CLOCK);
    chk("resync", 8'h04, 8'(n_resync));
    wb(1'b1, SYN, 8'h10);
    i_far.set_line(3'b000);
    i_far.set_line(3'b001);
    repeat (6) @(posedge CLOCK);
    chk("resync", 8'h04, 8'(n_resync));
    wb(1'b1, SYN, 8'h12);
    i_far.pulse_oof();
    repeat (6) @(posedge CLOCK);
    chk("resync", 8'h04, 8'(n_resync));
    pat_chk(1'b1, 15, 8'h00);
    pat_chk(1'b1, 1, 8'h01);
    pat_chk(1'b0, 1, 8'h01);
    pat_chk(1'b0, 1, 8'h00);
    wb(1'b1, ALM, 8'h02);
    pat_chk(1'b1, 16, 8'h00);
    repeat (60) @(posedge CLOCK);
    chk("remote alarm", 8'h01, REMOTE_ALARM);
    wb(1'b1, SYN, 8'h20);
    wb(1'b1, ALM, 8'h01);
    i_far.set_sf(2'b01);
    chk("remote alarm", 8'h01, REMOTE_ALARM);
    wb(1'b1, ALM, 8'h00);
    chk("remote alarm", 8'h00, REMOTE_ALARM);
    i_far.set_sf(2'b10);
    chk("remote alarm", 8'h01, REMOTE_ALARM);
    wb(1'b1, RXM, 8'hC1);
    wb(1'b1, tfmc_pkg::IDX_E1_CFG, 8'h40);
    chk("e1 decode", 8'h01, RX_E1_LINE_DECODE_EN);
    chk("remote alarm", 8'h00, REMOTE_ALARM);
    wrap_up();
  end
endmodule
